// File: design/idr_vendor_pkg.sv
/*
 * Constants for the vendor register group of the transceiver: register
 * addresses, field positions, reset values and measurement timing.
 * Assumes a single register clock at 40 MHz.
 */
// Functional notes
// - Latch bit 0 sets when the ID line goes driven to open with the rising enable on, or open to driven with the falling enable on.
// - Latch bits 1 and 2 are not implemented and always read zero.
// - Latch bit 3 sets when the measurement-complete flag rises while the effective measurement interrupt enable is on.
// - The latch register at 21h is read-only, its bits clear when it is read, and bits 7:4 read zero.
// - Every register in 00h to 3Fh answers to an immediate address and to an extended address alike.
// - The vendor registers sit at 30h to 3Fh and answer to immediate reads and writes.
// - Bits 6:5 of 31h pick the transmit amplitude, and all other bits of 31h read zero.
// - Headset audio is on only while bits 3:0 of 33h hold 1010, and bits 7:4 read zero.
// - Bits 2:0 of the measurement register report the measured resistance code.
// - The measurement register reads at 36h to 38h, loads at 36h, sets ones at 37h and clears ones at 38h.
// - Setting bit 4 starts a measurement, and the bit clears itself when the measurement ends.
// - With bit 6 set, alt_int rises once the measurement-complete flag asserts.
// - The effective measurement interrupt enable is bit 6 ORed with the carkit enable bit.
// - The complete flag asserts by itself when a measurement ends, and a measurement takes 282 us.
// - Reading the measurement register clears the complete flag, while reading the code elsewhere does not.
package idr_vendor_pkg;
	// ======================================================
	// Addresses
	localparam logic [7:0] ADDR_EVENT_LATCH = 8'h21;
	localparam logic [7:0] ADDR_HS_TX_AMP   = 8'h31;
	localparam logic [7:0] ADDR_AUDIO_KEY   = 8'h33;
	localparam logic [7:0] ADDR_MEAS_WR     = 8'h36;
	localparam logic [7:0] ADDR_MEAS_SET    = 8'h37;
	localparam logic [7:0] ADDR_MEAS_CLR    = 8'h38;
	localparam logic [7:0] ADDR_IMM_LAST    = 8'h3F;
	// ======================================================
	// Fields
	localparam int LATCH_ID_BIT   = 0;
	localparam int LATCH_MEAS_BIT = 3;
	localparam int AMP_LO         = 5;
	localparam int MEAS_DONE_BIT  = 3;
	localparam int MEAS_GO_BIT    = 4;
	localparam int MEAS_RSV_BIT   = 5;
	localparam int MEAS_IRQ_BIT   = 6;
	localparam logic [3:0] AUDIO_KEY_ON  = 4'hA;
	localparam logic [1:0] AMP_RESET     = 2'h0;
	localparam logic [3:0] AUDIO_RESET   = 4'h0;
	localparam logic [2:0] CODE_RESET    = 3'h0;
	localparam logic [7:0] BYTE_ZERO     = 8'h00;
	// ======================================================
	// Timing
	localparam int MEAS_TIME_US = 282;
	localparam int CLK_MHZ      = 40;
	localparam int MEAS_CYCLES  = MEAS_TIME_US * CLK_MHZ;
	localparam int CNT_W        = 14;
endpackage : idr_vendor_pkg

// File: design/idr_vendor_regs.sv
/*
 * Vendor register group: carkit event latch, transmit amplitude, headset
 * audio key and ID resistor measurement register with write/set/clear.
 * Assumes the ULPI command decoder delivers one-cycle read and write
 * strobes on clk_sys; analog ID and measurement inputs are asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none
module idr_vendor_regs
	import idr_vendor_pkg::*;
#(
	parameter int MEAS_CNT = MEAS_CYCLES
)(
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       arst_n,
	// Register command port from the ULPI decoder
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic       reg_ext,
	input  wire logic [5:0] reg_imm_addr,
	input  wire logic [7:0] reg_ext_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata_ff,
	// Carkit enable bits held elsewhere
	input  wire logic       id_open_rising_enable,
	input  wire logic       id_open_falling_enable,
	input  wire logic       carkit_meas_irq_enable,
	// Analog side
	input  wire logic       id_open_pin,
	input  wire logic [2:0] meas_result_pin,
	output logic            meas_active_ff,
	// Controls and status out
	output logic [1:0]      hs_amp_ff,
	output logic            audio_enable_ff,
	output logic [2:0]      code_status_ff,
	output logic            complete_status_ff,
	output logic            alt_int_ff
);
	// ======================================================
	// Address and input synchronisers
	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction

	logic [7:0] addr;
	logic       wr_latch;
	logic       rd_latch;
	logic       wr_amp;
	logic       wr_key;
	logic       wr_meas;
	logic       wr_set;
	logic       wr_clr;
	logic       rd_meas;

	assign addr     = reg_ext ? reg_ext_addr : {2'h0, reg_imm_addr};
	assign rd_latch = reg_rd && hit(addr, ADDR_EVENT_LATCH);
	assign wr_latch = reg_wr && hit(addr, ADDR_EVENT_LATCH);
	assign wr_amp   = reg_wr && hit(addr, ADDR_HS_TX_AMP);
	assign wr_key   = reg_wr && hit(addr, ADDR_AUDIO_KEY);
	assign wr_meas  = reg_wr && hit(addr, ADDR_MEAS_WR);
	assign wr_set   = reg_wr && hit(addr, ADDR_MEAS_SET);
	assign wr_clr   = reg_wr && hit(addr, ADDR_MEAS_CLR);
	assign rd_meas  = reg_rd && (addr >= ADDR_MEAS_WR) && (addr <= ADDR_MEAS_CLR);

	logic [1:0] id_sync_ff;
	logic [2:0] res_s1_ff;
	logic [2:0] res_s2_ff;
	logic       id_prev_ff;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			id_sync_ff <= 2'h0;
			res_s1_ff  <= 3'h0;
			res_s2_ff  <= 3'h0;
			id_prev_ff <= 1'b0;
		end else begin
			id_sync_ff <= {id_sync_ff[0], id_open_pin};
			res_s1_ff  <= meas_result_pin;
			res_s2_ff  <= res_s1_ff;
			id_prev_ff <= id_sync_ff[1];
		end
	end

	// ======================================================
	// Simple control registers
	logic [3:0] key_ff;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			hs_amp_ff <= AMP_RESET;
			key_ff    <= AUDIO_RESET;
		end else begin
			if (wr_amp)
				hs_amp_ff <= reg_wdata[AMP_LO +: 2];
			if (wr_key)
				key_ff <= reg_wdata[3:0];
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			audio_enable_ff <= 1'b0;
		else
			audio_enable_ff <= (key_ff == AUDIO_KEY_ON);
	end

	// ======================================================
	// Measurement register
	logic [2:0]       code_ff;
	logic             done_ff;
	logic             go_ff;
	logic             rsv_ff;
	logic             irq_en_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic             finish;
	logic [7:0]       meas_byte;
	logic [7:0]       nxt_meas;

	assign meas_byte = {1'b0, irq_en_ff, rsv_ff, go_ff, done_ff, code_ff};
	assign finish    = go_ff && (cnt_ff == CNT_W'(MEAS_CNT - 1));

	always_comb begin
		nxt_meas = meas_byte;
		if (wr_meas)
			nxt_meas = reg_wdata;
		else if (wr_set)
			nxt_meas = meas_byte | reg_wdata;
		else if (wr_clr)
			nxt_meas = meas_byte & ~reg_wdata;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			code_ff   <= CODE_RESET;
			go_ff     <= 1'b0;
			rsv_ff    <= 1'b0;
			irq_en_ff <= 1'b0;
		end else begin
			rsv_ff    <= nxt_meas[MEAS_RSV_BIT];
			irq_en_ff <= nxt_meas[MEAS_IRQ_BIT];
			if (finish) begin
				code_ff <= res_s2_ff;
				go_ff   <= 1'b0;
			end else begin
				code_ff <= nxt_meas[2:0];
				go_ff   <= nxt_meas[MEAS_GO_BIT];
			end
		end
	end

	// Finish outranks a clearing read of the flag
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			done_ff <= 1'b0;
		else if (finish)
			done_ff <= 1'b1;
		else if (rd_meas)
			done_ff <= 1'b0;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			cnt_ff <= '0;
		else if (!go_ff || finish)
			cnt_ff <= '0;
		else
			cnt_ff <= cnt_ff + CNT_W'(1);
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			meas_active_ff <= 1'b0;
		else
			meas_active_ff <= go_ff && !finish;
	end

	// ======================================================
	// Event latch
	logic eff_irq_en;
	logic done_prev_ff;
	logic id_event;
	logic meas_event;
	logic ev_id_ff;
	logic ev_meas_ff;

	assign eff_irq_en = irq_en_ff || carkit_meas_irq_enable;
	assign id_event   = (id_sync_ff[1] && !id_prev_ff && id_open_rising_enable)
	                 || (!id_sync_ff[1] && id_prev_ff && id_open_falling_enable);
	assign meas_event = done_ff && !done_prev_ff && eff_irq_en;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			done_prev_ff <= 1'b0;
			ev_id_ff     <= 1'b0;
			ev_meas_ff   <= 1'b0;
		end else begin
			done_prev_ff <= done_ff;
			// Set outranks the read clear so no event is lost
			ev_id_ff   <= id_event || (ev_id_ff && !rd_latch);
			ev_meas_ff <= meas_event || (ev_meas_ff && !rd_latch);
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			alt_int_ff <= 1'b0;
		else
			alt_int_ff <= ev_id_ff || ev_meas_ff;
	end

	// ======================================================
	// Read data and status
	logic [7:0] rd_val;

	always_comb begin
		rd_val = BYTE_ZERO;
		if (hit(addr, ADDR_EVENT_LATCH)) begin
			rd_val[LATCH_ID_BIT]   = ev_id_ff;
			rd_val[LATCH_MEAS_BIT] = ev_meas_ff;
		end else if (hit(addr, ADDR_HS_TX_AMP)) begin
			rd_val[AMP_LO +: 2] = hs_amp_ff;
		end else if (hit(addr, ADDR_AUDIO_KEY)) begin
			rd_val[3:0] = key_ff;
		end else if (addr >= ADDR_MEAS_WR && addr <= ADDR_MEAS_CLR) begin
			rd_val = meas_byte;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			reg_rdata_ff <= BYTE_ZERO;
		else if (reg_rd)
			reg_rdata_ff <= rd_val;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			code_status_ff     <= CODE_RESET;
			complete_status_ff <= 1'b0;
		end else begin
			code_status_ff     <= code_ff;
			complete_status_ff <= done_ff;
		end
	end

	// ======================================================
	// Assertions
	sequence s_go_write;
		(wr_meas || wr_set) && reg_wdata[MEAS_GO_BIT] && !go_ff;
	endsequence

	sequence s_finish;
		finish;
	endsequence

	a_go_starts: assert property (@(posedge clk_sys) disable iff (!arst_n)
		s_go_write |=> go_ff)
		else $error("go bit did not set after start write");

	a_finish_ends: assert property (@(posedge clk_sys) disable iff (!arst_n)
		s_finish |=> (done_ff && !go_ff))
		else $error("finish did not set done and clear go");

	a_done_clears: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(rd_meas && !finish) |=> !done_ff)
		else $error("measurement read did not clear done");

	a_latch_meas: assert property (@(posedge clk_sys) disable iff (!arst_n)
		($rose(done_ff) && eff_irq_en) |=> ev_meas_ff)
		else $error("measurement event not latched");

	a_latch_keep: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(rd_latch && id_event) |=> ev_id_ff)
		else $error("event lost on latch read");

	a_latch_rclr: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(rd_latch && !id_event && !meas_event) |=> (!ev_id_ff && !ev_meas_ff))
		else $error("latch read did not clear");

	a_latch_ro: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(wr_latch && !rd_latch && !id_event && !meas_event && !ev_id_ff && !ev_meas_ff) |=>
		(!ev_id_ff && !ev_meas_ff))
		else $error("write changed the event latch");

	a_alt_int: assert property (@(posedge clk_sys) disable iff (!arst_n)
		$rose(ev_meas_ff) |=> alt_int_ff)
		else $error("alt_int did not follow event");

	a_audio_key: assert property (@(posedge clk_sys) disable iff (!arst_n)
		##1 audio_enable_ff == ($past(key_ff) == AUDIO_KEY_ON))
		else $error("audio enable mismatch");

	a_amp_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
		wr_amp |=> hs_amp_ff == $past(reg_wdata[6:5]))
		else $error("amplitude field not stored");

	a_ext_same: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(reg_ext && reg_ext_addr == ADDR_HS_TX_AMP && reg_wr) |=>
		hs_amp_ff == $past(reg_wdata[6:5]))
		else $error("extended address write not taken");
endmodule : idr_vendor_regs
`default_nettype wire

// File: tb/ulpi_link_model.sv
/*
 * Behavioural link controller: issues single register reads and writes.
 * Assumes the design samples strobes on the rising edge of clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
module ulpi_link_model (
	// Clock and read data
	input  wire logic       clk_sys,
	input  wire logic [7:0] reg_rdata_ff,
	// Register command port
	output logic            reg_wr,
	output logic            reg_rd,
	output logic            reg_ext,
	output logic      [5:0] reg_imm_addr,
	output logic      [7:0] reg_ext_addr,
	output logic      [7:0] reg_wdata
);
	initial begin
		{reg_wr, reg_rd, reg_ext, reg_imm_addr, reg_ext_addr, reg_wdata} = '0;
	end
	// Released address and write-data lines show the inverse of their last value; reg_ext keeps its value
	task automatic put(input logic [7:0] a, input logic e);
		@(negedge clk_sys);
		reg_ext = e;
		reg_imm_addr = a[5:0];
		reg_ext_addr = a;
	endtask
	task automatic wr(input logic [7:0] a, input logic e, input logic [7:0] d);
		put(a, e);
		reg_wdata = (a == 8'h36 || a == 8'h37) ? (d & 8'hDF) : d;
		reg_wr = 1'b1;
		@(negedge clk_sys);
		reg_wr = 1'b0;
		reg_wdata = ~reg_wdata;
		reg_imm_addr = ~reg_imm_addr;
		reg_ext_addr = ~reg_ext_addr;
	endtask
	task automatic rd(input logic [7:0] a, input logic e, output logic [7:0] d);
		put(a, e);
		reg_rd = 1'b1;
		@(negedge clk_sys);
		reg_rd = 1'b0;
		d = reg_rdata_ff;
		reg_imm_addr = ~reg_imm_addr;
		reg_ext_addr = ~reg_ext_addr;
	endtask
endmodule // ulpi_link_model
`default_nettype wire

// File: tb/id_resistor_vendor_regs_tb.sv
/*
 * Self-checking bench for the vendor register group.
 * Assumes a short measurement count of 8 cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module id_resistor_vendor_regs_tb;
	import idr_vendor_pkg::*;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic reg_wr, reg_rd, reg_ext, rise_en = 0, fall_en = 0, ck_en = 0, id_pin = 0;
	logic [5:0] reg_imm_addr;
	logic [7:0] reg_ext_addr, reg_wdata, reg_rdata_ff, d;
	logic [2:0] res_pin = 0, code_status_ff;
	logic [1:0] hs_amp_ff;
	logic meas_active_ff, audio_enable_ff, complete_status_ff, alt_int_ff;
	int num_errors = 0;
	int cmp_count = 0;
	int cyc = 0;

	always #12.5 clk_sys = ~clk_sys;

	ulpi_link_model u_link (.clk_sys(clk_sys), .reg_rdata_ff(reg_rdata_ff),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_ext(reg_ext),
		.reg_imm_addr(reg_imm_addr), .reg_ext_addr(reg_ext_addr), .reg_wdata(reg_wdata));

	idr_vendor_regs #(.MEAS_CNT(8)) u_dut (.clk_sys(clk_sys), .arst_n(arst_n),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_ext(reg_ext),
		.reg_imm_addr(reg_imm_addr), .reg_ext_addr(reg_ext_addr),
		.reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
		.id_open_rising_enable(rise_en), .id_open_falling_enable(fall_en),
		.carkit_meas_irq_enable(ck_en), .id_open_pin(id_pin),
		.meas_result_pin(res_pin), .meas_active_ff(meas_active_ff),
		.hs_amp_ff(hs_amp_ff), .audio_enable_ff(audio_enable_ff),
		.code_status_ff(code_status_ff), .complete_status_ff(complete_status_ff),
		.alt_int_ff(alt_int_ff));

	// ======================================================
	// Checking helpers
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic e, input logic [7:0] x);
		u_link.rd(a, e, d);
		chk($sformatf("reg %h", a), x, d);
	endtask
	task automatic wait_hi(ref logic s);
		for (int i = 0; i < 40 && s !== 1'b1; i++) @(negedge clk_sys);
	endtask
	task automatic conclude;
		$display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// ======================================================
	// Scenarios
	task automatic t_reset;
		rdc(8'h21, 0, 8'h00);
		rdc(8'h31, 1, 8'h00);
		rdc(8'h33, 0, 8'h00);
		rdc(8'h36, 0, 8'h00);
		chk("outs", 8'h00, {meas_active_ff, hs_amp_ff, audio_enable_ff,
			code_status_ff, complete_status_ff});
	endtask
	task automatic t_amp;
		for (int i = 0; i < 4; i++) begin
			u_link.wr(8'h31, i[0], {1'b1, i[1:0], 5'h1F});
			rdc(8'h31, ~i[0], {1'b0, i[1:0], 5'h00});
			chk("amp", {6'h0, i[1:0]}, {6'h0, hs_amp_ff});
		end
	endtask
	task automatic t_audio;
		u_link.wr(8'h33, 1, 8'hFA);
		rdc(8'h33, 0, 8'h0A);
		chk("audio", 8'h01, {7'h0, audio_enable_ff});
		u_link.wr(8'h33, 0, 8'h0B);
		rdc(8'h33, 1, 8'h0B);
		chk("audio", 8'h00, {7'h0, audio_enable_ff});
	endtask
	task automatic t_meas(input logic irq, input logic ck, input logic [2:0] c);
		ck_en = ck;
		res_pin = c;
		u_link.wr(irq ? 8'h37 : 8'h36, 0, {1'b0, irq, 2'b01, 4'h0});
		@(negedge clk_sys);
		chk("active", 8'h01, {7'h0, meas_active_ff});
		wait_hi(complete_status_ff);
		chk("done", 8'h01, {7'h0, complete_status_ff});
		chk("active", 8'h00, {7'h0, meas_active_ff});
		repeat (4) @(negedge clk_sys);
		chk("alt", {7'h0, irq | ck}, {7'h0, alt_int_ff});
		rdc(8'h21, 0, {4'h0, irq | ck, 3'h0});
		rdc(8'h21, 1, 8'h00);
		chk("done", 8'h01, {7'h0, complete_status_ff});
		rdc(8'h36, 0, {1'b0, irq, 3'b001, c});
		rdc(8'h37, 0, {1'b0, irq, 3'b000, c});
		chk("done", 8'h00, {7'h0, complete_status_ff});
		chk("code", {5'h0, c}, {5'h0, code_status_ff});
		u_link.wr(8'h38, 0, 8'h40);
		rdc(8'h38, 1, {5'h0, c});
	endtask
	task automatic t_id;
		u_link.wr(8'h21, 0, 8'hFF);
		rdc(8'h21, 0, 8'h00);
		rise_en = 1;
		id_pin = 1;
		wait_hi(alt_int_ff);
		rdc(8'h21, 0, 8'h01);
		rise_en = 0;
		id_pin = 0;
		repeat (10) @(negedge clk_sys);
		id_pin = 1;
		repeat (10) @(negedge clk_sys);
		rdc(8'h21, 1, 8'h00);
		fall_en = 1;
		id_pin = 0;
		wait_hi(alt_int_ff);
		rdc(8'h21, 0, 8'h01);
		// Edge lands in the cycle of the next latch read
		rise_en = 1;
		id_pin = 1;
		@(negedge clk_sys);
		rdc(8'h21, 0, 8'h00);
		rdc(8'h21, 1, 8'h01);
	endtask

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			conclude();
		end
	end

	initial begin
		repeat (12) @(negedge clk_sys);
		arst_n = 1'b1;
		t_reset();
		t_amp();
		t_audio();
		t_meas(1, 0, 3'h5);
		t_meas(0, 1, 3'h7);
		t_meas(0, 0, 3'h2);
		t_id();
		conclude();
	end
endmodule // id_resistor_vendor_regs_tb
`default_nettype wire
